// file: adc_fmt_regs.vh
// Register map, field positions, reset values and codes for the ADC result formatter.
// Assumes a 32-bit APB slave with one register per aligned word.
`ifndef ADC_FMT_REGS_VH
`define ADC_FMT_REGS_VH

`define OFS_INPUT_SELECT   12'h000
`define OFS_CONTROL_STATUS 12'h004
`define OFS_RESULT_LOW     12'h008
`define OFS_RESULT_HIGH    12'h00c
`define OFS_IRQ_STATUS     12'h010
`define OFS_IRQ_MASK       12'h014
`define OFS_ACTIVE_SELECT  12'h018

`define BIT_LEFT_ADJUST    5
`define BIT_BUSY           6
`define BIT_DONE_FLAG      4
`define BIT_START          6

`define RST_INPUT_SELECT   8'h00
`define RST_IRQ_MASK       1'b0
`define RST_REFERENCE      2'b00
`define RST_CHANNEL        5'h00
`define RST_RESULT         10'h000

`define REF_EXTERNAL_PIN   2'b00
`define REF_ANALOG_SUPPLY  2'b01
`define REF_RESERVED       2'b10
`define REF_INTERNAL_256   2'b11

`define DIFF_POS_MAX       10'h1ff
`define DIFF_NEG_MIN       10'h200
`define SE_MAX             10'h3ff

`endif

// file: adc_result_format_refsel.v
// ADC result formatting, reference and channel selection with deferred update.
// Assumes an analog core that pulses conv_start/conv_end and supplies a raw
// signed difference or unsigned sample plus a differential indicator.
//
// How it works
// - Result readable in byte pair after done
// - Single-ended gives unsigned 10-bit code
// - Differential gives signed two's-complement code
// - Top result bit marks negative difference
// - Differential code saturates at both ends
// - Bits 7:6 choose one of three references
// - Reference change waits for conversion end
// - Left-adjust bit selects result justification
// - Left-adjust change acts on result immediately
// - Bits 4:0 pick inputs, gain; deferred
// - Done flag set when results updated
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_regs.vh"

module adc_result_format_refsel (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        conv_start,
    input  wire        conv_end,
    input  wire        sample_is_diff,
    input  wire [10:0] sample_raw,
    output reg  [1:0]  reference_select,
    output reg  [4:0]  channel_gain_select,
    output reg         conversion_busy,
    output wire        irq
);

    reg  [7:0]  adc_input_select_reg;
    reg  [9:0]  result_code;
    reg         conversion_done_flag;
    reg         irq_status;
    reg         irq_mask;
    wire        wr_en;
    wire        rd_en;
    wire        addr_ok;
    wire [15:0] result_pair;
    wire [9:0]  next_code;
    wire        result_sign_bit;
    wire        done_clear;

    // Inputs to the code path: 11-bit signed difference for differential,
    // unsigned value in the low bits for single-ended; wider range saturates.
    function [9:0] encode;
        input        diff;
        input [10:0] raw;
        begin
            if (diff) begin
                if (!raw[10] && raw[9]) begin
                    encode = `DIFF_POS_MAX;
                end else if (raw[10] && !raw[9]) begin
                    encode = `DIFF_NEG_MIN;
                end else begin
                    encode = raw[9:0];
                end
            end else if (raw[10]) begin
                encode = `SE_MAX;
            end else begin
                encode = raw[9:0];
            end
        end
    endfunction

    assign next_code       = encode(sample_is_diff, sample_raw);
    assign result_sign_bit = result_code[9];

    // Justification is applied on read, so the bit acts at once
    assign result_pair = adc_input_select_reg[`BIT_LEFT_ADJUST] ?
                         {result_sign_bit, result_code[8:0], 6'h00} :
                         {6'h00, result_code};

    assign pready  = 1'b1;
    assign addr_ok = (paddr == `OFS_INPUT_SELECT) || (paddr == `OFS_CONTROL_STATUS) ||
                     (paddr == `OFS_RESULT_LOW) || (paddr == `OFS_RESULT_HIGH) ||
                     (paddr == `OFS_IRQ_STATUS) || (paddr == `OFS_IRQ_MASK) ||
                     (paddr == `OFS_ACTIVE_SELECT);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && penable && !pwrite;
    assign done_clear = wr_en && (paddr == `OFS_CONTROL_STATUS) && pwdata[`BIT_DONE_FLAG];
    assign irq     = irq_status && irq_mask;

    // Software copy; all eight bits stored, reserved reference code included
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_input_select_reg <= `RST_INPUT_SELECT;
            irq_mask             <= `RST_IRQ_MASK;
        end else if (wr_en) begin
            if (paddr == `OFS_INPUT_SELECT) begin
                adc_input_select_reg <= pwdata[7:0];
            end else if (paddr == `OFS_IRQ_MASK) begin
                irq_mask <= pwdata[0];
            end
        end
    end

    // Active selection tracks the copy while idle and locks during conversion
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_select    <= `RST_REFERENCE;
            channel_gain_select <= `RST_CHANNEL;
        end else if (!conversion_busy || conv_end) begin
            reference_select    <= adc_input_select_reg[7:6];
            channel_gain_select <= adc_input_select_reg[4:0];
        end
    end

    // Result and flag update together; set wins over a same-cycle clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_busy      <= 1'b0;
            result_code          <= `RST_RESULT;
            conversion_done_flag <= 1'b0;
            irq_status           <= 1'b0;
        end else begin
            if (conv_end) begin
                conversion_busy <= 1'b0;
            end else if (conv_start) begin
                conversion_busy <= 1'b1;
            end
            if (conv_end && conversion_busy) begin
                result_code <= next_code;
            end
            if (conv_end && conversion_busy) begin
                conversion_done_flag <= 1'b1;
            end else if (done_clear) begin
                conversion_done_flag <= 1'b0;
            end
            if (conv_end && conversion_busy) begin
                irq_status <= 1'b1;
            end else if (rd_en && paddr == `OFS_IRQ_STATUS) begin
                irq_status <= 1'b0;
            end
        end
    end

    // Registered read data; zero for unmapped addresses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `OFS_INPUT_SELECT) begin
                prdata <= {24'h000000, adc_input_select_reg};
            end else if (paddr == `OFS_CONTROL_STATUS) begin
                prdata <= {25'h0000000, conversion_busy, 1'b0, conversion_done_flag, 4'h0};
            end else if (paddr == `OFS_RESULT_LOW) begin
                prdata <= {24'h000000, result_pair[7:0]};
            end else if (paddr == `OFS_RESULT_HIGH) begin
                prdata <= {24'h000000, result_pair[15:8]};
            end else if (paddr == `OFS_IRQ_STATUS) begin
                prdata <= {31'h00000000, irq_status};
            end else if (paddr == `OFS_IRQ_MASK) begin
                prdata <= {31'h00000000, irq_mask};
            end else if (paddr == `OFS_ACTIVE_SELECT) begin
                prdata <= {24'h000000, reference_select, 1'b0, channel_gain_select};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

endmodule
`default_nettype wire

// file: adc_fmt_chk_sva.sv
// Port checker for the ADC result formatter.
// Assumes zero-wait APB and one-cycle conversion pulses.
`timescale 1ns/1ps
`default_nettype none
module adc_fmt_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        conv_start,
    input wire logic        conv_end,
    input wire logic [1:0]  reference_select,
    input wire logic [4:0]  channel_gain_select,
    input wire logic        conversion_busy,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable;
    // Idle write of the select copy: active selection must follow it
    wire logic sw = acc && pwrite && paddr == 12'h000 && !conversion_busy && !conv_start;
    a_busy_start: assert property (conv_start |=> conversion_busy)
        else $error("busy not raised");
    a_busy_end: assert property (conv_end |=> !conversion_busy)
        else $error("busy not dropped");
    a_ref_locked: assert property (conversion_busy && !conv_end |=> $stable(reference_select))
        else $error("reference moved");
    a_chan_locked: assert property (conversion_busy && !conv_end |=> $stable(channel_gain_select))
        else $error("channel moved");
    a_ref_follow: assert property (sw |-> ##2 reference_select == $past(pwdata[7:6], 2))
        else $error("reference not taken");
    a_chan_follow: assert property (sw |-> ##2 channel_gain_select == $past(pwdata[4:0], 2))
        else $error("channel not taken");
    a_irq_cause: assert property ($rose(irq) && !$past(acc && pwrite) |-> $past(conv_end))
        else $error("irq without end");
    a_sel_readback: assert property (acc && !pwrite && paddr == 12'h018 |->
        prdata[7:0] == {$past(reference_select), 1'b0, $past(channel_gain_select)})
        else $error("active select readback");
endmodule
bind adc_result_format_refsel adc_fmt_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .conv_start, .conv_end, .reference_select,
    .channel_gain_select, .conversion_busy, .irq);
`default_nettype wire

// file: adc_core_model.sv
// Analog core stand-in: start pulse, delay, end pulse with one sample.
// Assumes the bench calls convert only between conversions.
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    input  wire logic        pclk,
    output var  logic        conv_start,
    output var  logic        conv_end,
    output var  logic        sample_is_diff,
    output var  logic [10:0] sample_raw
);
    initial begin
        conv_start = 1'b0;
        conv_end = 1'b0;
        sample_is_diff = 1'b0;
        sample_raw = 11'h000;
    end
    task automatic convert(input logic d, input logic [10:0] r, input int len);
        @(posedge pclk) conv_start <= 1'b1;
        sample_is_diff <= d;
        @(posedge pclk) conv_start <= 1'b0;
        repeat (len) @(posedge pclk);
        conv_end <= 1'b1;
        sample_raw <= r;
        @(posedge pclk) conv_end <= 1'b0;
        // Sample is meaningless off the end pulse, so show a changed value
        sample_raw <= ~r;
    endtask
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the ADC result formatter.
// Assumes an APB master here and the analog core stand-in beside it.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic [10:0] raw, r;
    logic [9:0]  code;
    logic [7:0]  s, lo;
    logic [1:0]  rs;
    logic [4:0]  cg;
    logic        pready, cs, ce, sd, busy, irq, slverr, e;
    logic [10:0] cor [6] = '{11'h1ff, 11'h200, 11'h600, 11'h5ff, 11'h7ff, 11'h000};
    integer      seed = 32'h92218029, err_count = 0, tests_run = 0;
    adc_result_format_refsel i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr(slverr), .conv_start(cs), .conv_end(ce),
        .sample_is_diff(sd), .sample_raw(raw), .reference_select(rs),
        .channel_gain_select(cg), .conversion_busy(busy), .irq);
    adc_core_model i_core (.pclk, .conv_start(cs), .conv_end(ce), .sample_is_diff(sd),
        .sample_raw(raw));
    initial forever #10 pclk = ~pclk;
    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = slverr;
        if (n >= 16) begin
            err_count++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [9:0] fmt(input logic d, input logic [10:0] v);
        if (d)
            return ($signed(v) > 511) ? 10'h1ff : ($signed(v) < -512) ? 10'h200 : v[9:0];
        return v[10] ? 10'h3ff : v[9:0];
    endfunction
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        xfer(0, 12'h000, 0);
        chk(q, 32'h0);
        chk(e, 0);
        xfer(0, 12'h01c, 0);
        chk(q, 32'h0);
        chk(e, 1);
        for (int i = 0; i < 14; i++) begin
            s = $random(seed);
            r = (i < 6) ? cor[i] : $random(seed);
            xfer(1, 12'h014, i % 2);
            xfer(1, 12'h000, s);
            fork
                i_core.convert(i < 6 || s[0], r, 6);
                xfer(1, 12'h000, s ^ 8'hc5);
            join
            code = fmt(i < 6 || s[0], r);
            xfer(0, 12'h018, 0);
            chk(q, {s[7:6] ^ 2'b11, 1'b0, s[4:0] ^ 5'h05});
            chk({rs, cg}, {s[7:6] ^ 2'b11, s[4:0] ^ 5'h05});
            chk(busy, 0);
            xfer(0, 12'h004, 0);
            chk(q[6:4], 3'b001);
            chk(irq, i % 2);
            xfer(0, 12'h010, 0);
            chk(q[0], 1'b1);
            xfer(1, 12'h004, 32'h10);
            chk(irq, 0);
            for (int j = 0; j < 2; j++) begin
                xfer(0, 12'h008, 0);
                lo = q[7:0];
                xfer(0, 12'h00c, 0);
                chk({q[7:0], lo}, (s[5] ^ j[0]) ? {code, 6'h0} : {6'h0, code});
                xfer(1, 12'h000, s ^ (j[0] ? 8'hc5 : 8'he5));
            end
            $display("test %0d done", i);
        end
        finish_test();
    end
endmodule
`default_nettype wire
